// file: tb/rail_regulator_model.sv
`timescale 1ns/1ps
module rail_regulator_model #(
    parameter int RAMP_CYCLES = 3
) (
    input wire logic ref_clk,
    input wire logic [11:0] railEnablePin,
    output logic [11:0] powerGood
);
    int ramp [12];
    // A dropped enable discharges at once; a raised one needs a ramp before good
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 12; i++) begin
            if (!railEnablePin[i]) begin
                ramp[i] <= 0;
                powerGood[i] <= 1'b0;
            end else if (ramp[i] < RAMP_CYCLES) begin
                ramp[i] <= ramp[i] + 1;
            end else begin
                powerGood[i] <= 1'b1;
            end
        end
    end
endmodule : rail_regulator_model

// file: tb/rail_slot_sequencer_sva.sv
`timescale 1ns/1ps
module rail_slot_sequencer_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire logic startPowerUp,
    input wire logic startPowerDown,
    input wire logic startSleepExit,
    input wire logic startSleepEntry,
    input wire logic faultSafeState,
    input wire logic [11:0] railEnablePin,
    input wire logic slowClockOutput,
    input wire logic sequenceBusy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Accepted trigger, and the pins that config bits never move
    wire logic trig = (startPowerUp | startPowerDown | startSleepExit | startSleepEntry)
        & ~faultSafeState;
    wire logic [8:0] seqOut = {railEnablePin[11:8], railEnablePin[3:0], slowClockOutput};
    // Shortest slot is four cycles here, so nothing may move right after a trigger
    property p_min_slot;
        trig ##1 !faultSafeState [*2] |=> seqOut == $past(seqOut, 2);
    endproperty
    a_min_slot: assert property (p_min_slot) else $error("pin moved in first slot");
    property p_busy;
        trig ##1 !faultSafeState [*8] |-> sequenceBusy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped early");
    property p_fault_rails;
        faultSafeState |=> railEnablePin == 12'h000;
    endproperty
    a_fault_rails: assert property (p_fault_rails) else $error("rail high in fault");
    property p_fault_clock;
        faultSafeState |=> !slowClockOutput;
    endproperty
    a_fault_clock: assert property (p_fault_clock) else $error("clock on in fault");
    property p_reserved;
        regRead && regAddr == 8'h30 |=> regReadData[3:1] == 3'b000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_clock_on;
        $rose(slowClockOutput) |-> $past(sequenceBusy);
    endproperty
    a_clock_on: assert property (p_clock_on) else $error("clock on outside sequence");
    property p_clock_off;
        $fell(slowClockOutput) |-> $past(sequenceBusy) || $past(faultSafeState);
    endproperty
    a_clock_off: assert property (p_clock_off) else $error("clock off unprompted");
    property p_rail_move;
        $changed(railEnablePin[3:0]) |-> $past(sequenceBusy) || $past(faultSafeState);
    endproperty
    a_rail_move: assert property (p_rail_move) else $error("rail moved while idle");
    c_up: cover property (startPowerUp ##1 sequenceBusy);
    c_clock: cover property ($rose(slowClockOutput));
    c_fault: cover property (faultSafeState ##1 railEnablePin == 12'h000);
endmodule : rail_slot_sequencer_sva

bind rail_slot_sequencer rail_slot_sequencer_sva i_rail_slot_sequencer_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regRead(regRead),
    .regReadData(regReadData), .startPowerUp(startPowerUp), .startPowerDown(startPowerDown),
    .startSleepExit(startSleepExit), .startSleepEntry(startSleepEntry),
    .faultSafeState(faultSafeState), .railEnablePin(railEnablePin),
    .slowClockOutput(slowClockOutput), .sequenceBusy(sequenceBusy)
);

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import rail_slot_sequencer_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWrite = 1'b0;
    logic [7:0] regWriteData = 8'h00;
    logic regRead = 1'b0;
    logic [7:0] regReadData;
    logic nvmLoad = 1'b0;
    logic [7:0] nvmAddr = 8'h00;
    logic [7:0] nvmData = 8'h00;
    logic protectLock = 1'b0;
    logic [3:0] start = 4'h0;
    logic faultSafeState = 1'b0;
    logic [11:0] railEnablePin;
    logic [11:0] powerGood;
    logic slowClockOutput;
    logic sequenceBusy;
    int fails = 0;
    int num_checks = 0;
    int cycleCount = 0;
    int t0 = 0;
    // Short half steps keep slots to a few cycles: 4 small, 16 large
    rail_slot_sequencer #(.HALF_STEP_SMALL_CYCLES(4), .HALF_STEP_LARGE_CYCLES(16))
        i_rail_slot_sequencer (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
        .nvmLoad(nvmLoad), .nvmAddr(nvmAddr), .nvmData(nvmData), .protectLock(protectLock),
        .startPowerUp(start[0]), .startPowerDown(start[1]), .startSleepExit(start[2]),
        .startSleepEntry(start[3]), .faultSafeState(faultSafeState),
        .railEnablePin(railEnablePin), .slowClockOutput(slowClockOutput),
        .sequenceBusy(sequenceBusy)
    );
    rail_regulator_model i_rail_regulator_model (
        .ref_clk(ref_clk), .railEnablePin(railEnablePin), .powerGood(powerGood)
    );
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cycleCount++;
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Strobes move on falling edges; an idle edge after each call keeps pulses apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(negedge ref_clk);
        regWrite = 1'b0;
        @(negedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        regRead = 1'b1;
        @(negedge ref_clk);
        regRead = 1'b0;
        chk({8'h00, regReadData}, {8'h00, exp}, "read");
        @(negedge ref_clk);
    endtask : rd
    task automatic load(input logic [7:0] a, input logic [7:0] d);
        nvmAddr = a;
        nvmData = d;
        nvmLoad = 1'b1;
        @(negedge ref_clk);
        nvmLoad = 1'b0;
        @(negedge ref_clk);
    endtask : load
    // Slot edges are counted from the edge that takes the trigger
    task automatic trig(input int which);
        start[which] = 1'b1;
        @(negedge ref_clk);
        start[which] = 1'b0;
        t0 = cycleCount;
    endtask : trig
    task automatic pinsAt(input int k, input logic [12:0] exp);
        while (cycleCount < t0 + k) @(negedge ref_clk);
        chk({3'h0, slowClockOutput, railEnablePin}, {3'h0, exp}, "pins");
    endtask : pinsAt
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        for (int a = 8'h30; a <= 8'h3f; a++) rd(a[7:0], 8'h00);
        // Loads pass a locked group, bus writes do not
        protectLock = 1'b1;
        load(8'h33, 8'h12);
        wr(8'h31, 8'h55);
        rd(8'h33, 8'h12);
        rd(8'h31, 8'h00);
        protectLock = 1'b0;
        wr(8'h37, 8'h01);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'hf1);
        rd(8'h40, 8'h00);
        // Channel 5 is mapped, so only 6 to 8 follow the config bits
        wr(8'h30, 8'hf0);
        @(negedge ref_clk);
        chk({4'h0, railEnablePin}, 16'h00e0, "general");
        chk({15'h0, railEnablePin[7]}, 16'h0001, "channel 8");
        wr(8'h30, 8'h00);
        @(negedge ref_clk);
        chk({4'h0, railEnablePin}, 16'h0000, "general low");
        // Power-up, slot 12 cycles: rail 1, clock, rail 2 in slots 1 to 3
        wr(8'h31, 8'h01);
        wr(8'h34, 8'h30);
        wr(8'h3f, 8'h21);
        trig(0);
        pinsAt(11, 13'h0000);
        pinsAt(12, 13'h0001);
        pinsAt(23, 13'h0001);
        pinsAt(24, 13'h1001);
        pinsAt(36, 13'h1003);
        chk({15'h0, powerGood[0]}, 16'h0001, "rail good");
        pinsAt(179, 13'h1003);
        chk({15'h0, sequenceBusy}, 16'h0001, "busy");
        pinsAt(180, 13'h1003);
        chk({15'h0, sequenceBusy}, 16'h0000, "idle");
        // Power-down on the large step, slot 16 cycles; rail 2 is not sequenced
        wr(8'h30, 8'h01);
        wr(8'h32, 8'h00);
        trig(1);
        pinsAt(15, 13'h1003);
        pinsAt(16, 13'h0003);
        pinsAt(31, 13'h0003);
        pinsAt(32, 13'h0002);
        pinsAt(240, 13'h0002);
        // Sleep maps, not rail maps, place rail 1 in slot 2 here
        wr(8'h30, 8'h00);
        wr(8'h53, 8'h21);
        wr(8'h5f, 8'h10);
        trig(2);
        pinsAt(12, 13'h1002);
        pinsAt(24, 13'h1003);
        trig(3);
        pinsAt(4, 13'h1002);
        faultSafeState = 1'b1;
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk({3'h0, slowClockOutput, railEnablePin}, 16'h0000, "fault");
        faultSafeState = 1'b0;
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : testbench

// file: verilog/rail_slot_sequencer.sv
`timescale 1ns/1ps
`include "rail_slot_sequencer_defines.svh"

module rail_slot_sequencer
    import rail_slot_sequencer_pkg::*;
#(
    parameter int HALF_STEP_SMALL_CYCLES =
        (`SLOT_STEP_SMALL_US * `CLOCK_MHZ) / `HALF_STEP_DIVISOR,
    parameter int HALF_STEP_LARGE_CYCLES =
        (`SLOT_STEP_LARGE_US * `CLOCK_MHZ) / `HALF_STEP_DIVISOR
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWriteData,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire logic nvmLoad,
    input wire logic [7:0] nvmAddr,
    input wire logic [7:0] nvmData,
    input wire logic protectLock,
    input wire logic startPowerUp,
    input wire logic startPowerDown,
    input wire logic startSleepExit,
    input wire logic startSleepEntry,
    input wire logic faultSafeState,
    output logic [11:0] railEnablePin,
    output logic slowClockOutput,
    output logic sequenceBusy
);

    logic [7:0] sequenceConfig;
    logic [7:0] upSlotTime;
    logic [7:0] downSlotTime;
    logic [7:0] railSlotMap [`RAIL_COUNT];
    logic [7:0] sleepSlotMap [`RAIL_COUNT];
    logic [7:0] slowClockMap;
    logic [7:0] sleepClockMap;

    seq_state_type seqState;
    seq_mode_type seqMode;
    logic [3:0] slotCount;
    logic [8:0] halfUnits;
    logic [15:0] halfCycles;
    logic [8:0] slotHalfUnits;
    logic [15:0] halfStepLast;
    logic slotEnd;
    logic anyStart;
    logic driveLevel;
    logic busWrite;

    // True when an address falls in an inclusive register range
    function automatic logic inRange(input logic [7:0] addr, input logic [7:0] first,
                                     input logic [7:0] last);
        inRange = (addr >= first) && (addr <= last);
    endfunction : inRange

    // Slot length in half steps: time * step + step / 2
    function automatic logic [8:0] halfUnitsOf(input logic [7:0] slotTime);
        halfUnitsOf = {slotTime, 1'b1};
    endfunction : halfUnitsOf

    // Slot number that the active mode assigns from a map byte
    function automatic logic [3:0] slotOf(input logic [7:0] mapByte,
                                          input seq_mode_type mode);
        if (mode == MODE_POWER_UP || mode == MODE_SLEEP_EXIT) begin
            slotOf = mapByte[`MAP_UP_HI:`MAP_UP_LO];
        end else begin
            slotOf = mapByte[`MAP_DOWN_HI:`MAP_DOWN_LO];
        end
    endfunction : slotOf

    // Entry of a twelve-register map block that an in-range address selects
    function automatic logic [3:0] mapIndex(input logic [7:0] addr, input logic [7:0] first);
        mapIndex = 4'(addr - first);
    endfunction : mapIndex

    // Power-up and sleep-exit walk upward: up fields, pins driven high
    function automatic logic isUpward(input seq_mode_type mode);
        isUpward = (mode == MODE_POWER_UP) || (mode == MODE_SLEEP_EXIT);
    endfunction : isUpward

    // Output picked at this slot end: power walks read the power map, sleep
    // walks the sleep map; slot 0 never equals a running count
    function automatic logic slotHit(input logic [7:0] powerMap, input logic [7:0] sleepMap,
                                     input seq_mode_type mode, input logic [3:0] count);
        if (mode == MODE_POWER_UP || mode == MODE_POWER_DOWN) begin
            slotHit = (slotOf(powerMap, mode) == count);
        end else begin
            slotHit = (slotOf(sleepMap, mode) == count);
        end
    endfunction : slotHit

    // Bus writes are dropped while the group is locked; the load port is not gated
    assign busWrite = regWrite && !protectLock;

    // Register file: non-volatile load first, then software writes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sequenceConfig <= `RESET_REG;
            upSlotTime <= `RESET_REG;
            downSlotTime <= `RESET_REG;
            slowClockMap <= `RESET_REG;
            sleepClockMap <= `RESET_REG;
            for (int i = 0; i < `RAIL_COUNT; i++) begin
                railSlotMap[i] <= `RESET_REG;
                sleepSlotMap[i] <= `RESET_REG;
            end
        end else if (nvmLoad || busWrite) begin
            // Power-on contents arrive over the load port after reset release
            if (nvmLoad) begin
                case (nvmAddr)
                    `OFS_SEQUENCE_CONFIG: begin
                        sequenceConfig <= nvmData & `CONFIG_WRITE_MASK;
                    end
                    `OFS_UP_SLOT_TIME: upSlotTime <= nvmData;
                    `OFS_DOWN_SLOT_TIME: downSlotTime <= nvmData;
                    `OFS_SLOW_CLOCK_MAP: slowClockMap <= nvmData;
                    `OFS_SLEEP_CLOCK_MAP: sleepClockMap <= nvmData;
                    default: begin
                        if (inRange(nvmAddr, `OFS_RAIL_MAP_FIRST, `OFS_RAIL_MAP_LAST)) begin
                            railSlotMap[mapIndex(nvmAddr, `OFS_RAIL_MAP_FIRST)] <= nvmData;
                        end
                        if (inRange(nvmAddr, `OFS_SLEEP_MAP_FIRST, `OFS_SLEEP_MAP_LAST)) begin
                            sleepSlotMap[mapIndex(nvmAddr, `OFS_SLEEP_MAP_FIRST)] <= nvmData;
                        end
                    end
                endcase
            end else begin
                case (regAddr)
                    `OFS_SEQUENCE_CONFIG: begin
                        sequenceConfig <= regWriteData & `CONFIG_WRITE_MASK;
                    end
                    `OFS_UP_SLOT_TIME: upSlotTime <= regWriteData;
                    `OFS_DOWN_SLOT_TIME: downSlotTime <= regWriteData;
                    `OFS_SLOW_CLOCK_MAP: slowClockMap <= regWriteData;
                    `OFS_SLEEP_CLOCK_MAP: sleepClockMap <= regWriteData;
                    default: begin
                        if (inRange(regAddr, `OFS_RAIL_MAP_FIRST, `OFS_RAIL_MAP_LAST)) begin
                            railSlotMap[mapIndex(regAddr, `OFS_RAIL_MAP_FIRST)] <= regWriteData;
                        end
                        // Sleep maps are a second, independent set
                        if (inRange(regAddr, `OFS_SLEEP_MAP_FIRST, `OFS_SLEEP_MAP_LAST)) begin
                            sleepSlotMap[mapIndex(regAddr, `OFS_SLEEP_MAP_FIRST)] <=
                                regWriteData;
                        end
                    end
                endcase
            end
        end
    end

    // Read port, one cycle latency; unmapped addresses read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regReadData <= `RESET_REG;
        end else if (regRead) begin
            case (regAddr)
                `OFS_SEQUENCE_CONFIG: regReadData <= sequenceConfig;
                `OFS_UP_SLOT_TIME: regReadData <= upSlotTime;
                `OFS_DOWN_SLOT_TIME: regReadData <= downSlotTime;
                `OFS_SLOW_CLOCK_MAP: regReadData <= slowClockMap;
                `OFS_SLEEP_CLOCK_MAP: regReadData <= sleepClockMap;
                default: begin
                    if (inRange(regAddr, `OFS_RAIL_MAP_FIRST, `OFS_RAIL_MAP_LAST)) begin
                        regReadData <= railSlotMap[mapIndex(regAddr, `OFS_RAIL_MAP_FIRST)];
                    end else if (inRange(regAddr, `OFS_SLEEP_MAP_FIRST,
                                         `OFS_SLEEP_MAP_LAST)) begin
                        regReadData <= sleepSlotMap[mapIndex(regAddr, `OFS_SLEEP_MAP_FIRST)];
                    end else begin
                        regReadData <= `RESET_REG;
                    end
                end
            endcase
        end
    end

    // Step size and slot length; the step bit is read live, so a change mid-slot
    // stretches or shortens the half step in progress and every later one
    assign halfStepLast = sequenceConfig[`BIT_SLOT_STEP_SELECT] ?
        16'(HALF_STEP_LARGE_CYCLES - 1) : 16'(HALF_STEP_SMALL_CYCLES - 1);
    assign slotHalfUnits = isUpward(seqMode) ?
        halfUnitsOf(upSlotTime) : halfUnitsOf(downSlotTime);
    // Compares use >= so a step cut short mid-slot ends the half step at once and a slot time
    // cut short ends the slot at the current half step's end, instead of running the counters round their whole range
    assign slotEnd = (seqState == SEQ_RUN) && (halfCycles >= halfStepLast) &&
        (halfUnits >= slotHalfUnits - 9'd1);
    assign anyStart = startPowerUp || startPowerDown || startSleepExit || startSleepEntry;
    assign driveLevel = isUpward(seqMode);

    // Walker state: a fault aborts, a trigger while running keeps it running
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seqState <= SEQ_IDLE;
        end else if (faultSafeState) begin
            seqState <= SEQ_IDLE;
        end else begin
            unique case (seqState)
                SEQ_IDLE: begin
                    if (anyStart) begin
                        seqState <= SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    if (!anyStart && slotEnd && slotCount == `LAST_SLOT) begin
                        seqState <= SEQ_IDLE;
                    end
                end
                // The two spare codes of the state fall back to idle
                default: begin
                    seqState <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Sequence kind, taken with the trigger; up, down, exit, entry in priority
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seqMode <= MODE_POWER_UP;
        end else if (!faultSafeState && anyStart) begin
            if (startPowerUp) begin
                seqMode <= MODE_POWER_UP;
            end else if (startPowerDown) begin
                seqMode <= MODE_POWER_DOWN;
            end else if (startSleepExit) begin
                seqMode <= MODE_SLEEP_EXIT;
            end else begin
                seqMode <= MODE_SLEEP_ENTRY;
            end
        end
    end

    // Slot counter; it rests at 0, which no field of a running walk matches
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slotCount <= `NO_SLOT;
        end else if (faultSafeState) begin
            slotCount <= `NO_SLOT;
        end else if (anyStart) begin
            slotCount <= `FIRST_SLOT;
        end else if (slotEnd) begin
            if (slotCount == `LAST_SLOT) begin
                slotCount <= `NO_SLOT;
            end else begin
                slotCount <= slotCount + 4'd1;
            end
        end
    end

    // Half-step cycle counter and half-step counter within the slot
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            halfCycles <= '0;
            halfUnits <= '0;
        end else if (faultSafeState || anyStart || seqState == SEQ_IDLE || slotEnd) begin
            halfCycles <= '0;
            halfUnits <= '0;
        end else if (halfCycles >= halfStepLast) begin
            halfCycles <= '0;
            halfUnits <= halfUnits + 9'd1;
        end else begin
            halfCycles <= halfCycles + 16'd1;
        end
    end

    // Rail enables: sequenced channels move at their slot end, general outputs
    // follow the config bits, fault state pulls every pin low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            railEnablePin <= '0;
        end else if (faultSafeState) begin
            railEnablePin <= '0;
        end else begin
            for (int i = 0; i < `RAIL_COUNT; i++) begin
                if (i >= `GENERAL_FIRST_CHANNEL && i <= `GENERAL_LAST_CHANNEL &&
                    railSlotMap[i] == `RESET_REG && sleepSlotMap[i] == `RESET_REG) begin
                    // Channels 5 to 8 double as plain outputs when unsequenced
                    railEnablePin[i] <= sequenceConfig[i];
                end else if (slotEnd &&
                             slotHit(railSlotMap[i], sleepSlotMap[i], seqMode, slotCount)) begin
                    railEnablePin[i] <= driveLevel;
                end
            end
        end
    end

    // Slow clock output enable; slot 0 never matches a running count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slowClockOutput <= 1'b0;
        end else if (faultSafeState) begin
            slowClockOutput <= 1'b0;
        end else if (slotEnd &&
                     slotHit(slowClockMap, sleepClockMap, seqMode, slotCount)) begin
            slowClockOutput <= driveLevel;
        end
    end

    // Busy flag, registered so the port comes straight from a flip-flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sequenceBusy <= 1'b0;
        end else if (faultSafeState) begin
            sequenceBusy <= 1'b0;
        end else if (anyStart) begin
            sequenceBusy <= 1'b1;
        end else if (slotEnd && slotCount == `LAST_SLOT) begin
            sequenceBusy <= 1'b0;
        end
    end

endmodule : rail_slot_sequencer

// file: verilog/rail_slot_sequencer_defines.svh
`ifndef RAIL_SLOT_SEQUENCER_DEFINES_SVH
`define RAIL_SLOT_SEQUENCER_DEFINES_SVH

// Register offsets
`define OFS_SEQUENCE_CONFIG 8'h30
`define OFS_UP_SLOT_TIME 8'h31
`define OFS_DOWN_SLOT_TIME 8'h32
`define OFS_RAIL_MAP_FIRST 8'h33
`define OFS_RAIL_MAP_LAST 8'h3e
`define OFS_SLOW_CLOCK_MAP 8'h3f
`define OFS_SLEEP_MAP_FIRST 8'h53
`define OFS_SLEEP_MAP_LAST 8'h5e
`define OFS_SLEEP_CLOCK_MAP 8'h5f

// Field positions in the sequencing configuration register
`define BIT_SLOT_STEP_SELECT 0
`define BIT_GENERAL_OUTPUT_5 4
`define BIT_GENERAL_OUTPUT_8 7
`define CONFIG_WRITE_MASK 8'hf1

// Map fields
`define MAP_UP_HI 7
`define MAP_UP_LO 4
`define MAP_DOWN_HI 3
`define MAP_DOWN_LO 0

// Channel counts and indices
`define RAIL_COUNT 12
`define GENERAL_FIRST_CHANNEL 4
`define GENERAL_LAST_CHANNEL 7

// Reset values before the non-volatile load, and slot counter limits
`define RESET_REG 8'h00
`define NO_SLOT 4'h0
`define FIRST_SLOT 4'h1
`define LAST_SLOT 4'hf

// Timing
`define CLOCK_MHZ 100
`define SLOT_STEP_SMALL_US 250
`define SLOT_STEP_LARGE_US 1000
`define HALF_STEP_DIVISOR 2

`endif

// file: verilog/rail_slot_sequencer_pkg.sv
package rail_slot_sequencer_pkg;

    // Sequencer activity, Gray coded
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01
    } seq_state_type;

    // Which map and direction a running sequence uses
    typedef enum logic [1:0] {
        MODE_POWER_UP = 2'b00,
        MODE_POWER_DOWN = 2'b01,
        MODE_SLEEP_EXIT = 2'b11,
        MODE_SLEEP_ENTRY = 2'b10
    } seq_mode_type;

endpackage : rail_slot_sequencer_pkg
